//--- hw/sem_map.svh
`ifndef SEM_MAP_SVH
`define SEM_MAP_SVH

// Register offsets
`define SEM_ADDR_DS_INPUT_MASK   8'hea
`define SEM_ADDR_DS_VT_MASK      8'heb
`define SEM_ADDR_INPUT_ERR_MASK  8'hec
`define SEM_ADDR_MISC_ERR_MASK   8'hed
`define SEM_ADDR_ZONE_ONE_OFS    8'hee
`define SEM_ADDR_ZONE_TWO_OFS    8'hef

// Reset values
`define SEM_RST_DS_INPUT_MASK    8'hff
`define SEM_RST_DS_VT_MASK       8'h07
`define SEM_RST_INPUT_ERR_MASK   8'hff
`define SEM_RST_MISC_ERR_MASK    8'h3f
`define SEM_RST_ZONE_OFS         8'h00

// Writable bits per register
`define SEM_WMASK_DS_VT          8'h0f
`define SEM_WMASK_MISC           8'h3f
`define SEM_WMASK_ZONE           8'h3f

// Field positions
`define SEM_BIT_ANALOG13         1
`define SEM_BIT_ANALOG14         2
`define SEM_BIT_DS_TEMP          3
`define SEM_BIT_REG_HOT          0
`define SEM_BIT_INPUT8           3
`define SEM_BIT_DYN_CORE         4

// Sleep-state field encoding
`define SEM_SLEEP_DEEP           2'h3

`endif

//--- hw/sem_pkg.sv
package sem_pkg;

  // Raw error events from the monitoring logic
  typedef struct packed {
    logic [7:0] inputErr;
    logic       analog13Err;
    logic       analog14Err;
    logic [1:0] zoneTempErr;
    logic [1:0] zoneDiodeErr;
    logic       regulatorHotEvent;
    logic       input8Err;
    logic       dynCoreErr;
  } sem_events_t;

  typedef struct packed {
    logic [8:0] zoneOne;
    logic [8:0] zoneTwo;
  } sem_temps_t;

endpackage

//--- hw/sem_sleep_error_mask.sv
`timescale 1ns/100ps
`include "sem_map.svh"

// What this block does
// - In deep sleep, set input mask bits suppress their input errors; reset FFh.
// - In deep sleep, bits 1 and 2 suppress analog channel 13, 14 errors.
// - In deep sleep, bit 3 suppresses zone 1 and 2 temperature, diode errors.
// - Input error mask bit n masks input n in every state; reset FFh.
// - Input mask gates status bits only; live input state stays unmasked.
// - Misc mask bit 0 masks regulator hot events; register resets 3Fh.
// - Misc mask bit 3 masks general input eight events.
// - Misc mask bit 4 masks dynamic core-voltage limit events.
// - Zone offsets are six-bit signed, reset zero, added to each measurement.
// - Adjusted temperature feeds readings, limits and fans as the true value.
// - Offset spans +31 to -32 degrees; sign-extend before adding.
// - Sleep field 11 selects deep sleep; entered while reset input asserted.
module sem_sleep_error_mask
  import sem_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  wrData,
  output logic      [7:0]  rdData,
  output logic             rdHit,
  input  wire logic [1:0]  sleepState,
  input  wire logic        resetInput_n,
  input  wire sem_events_t rawEvents,
  input  wire logic [7:0]  liveInputs,
  input  wire sem_temps_t  measTemps,
  input  wire logic        measValid,
  output sem_events_t      gatedEvents,
  output logic      [7:0]  liveInputState,
  output sem_temps_t       adjTemps,
  output logic             adjValid
);

  // ==========================================================
  // Register storage
  logic [7:0] deepSleepInputMask;
  logic [7:0] deepSleepVoltageTempMask;
  logic [7:0] inputErrorMask;
  logic [7:0] miscErrorMask;
  logic [7:0] zoneOneOffset;
  logic [7:0] zoneTwoOffset;
  logic [7:0] next_deepSleepInputMask;
  logic [7:0] next_deepSleepVoltageTempMask;
  logic [7:0] next_inputErrorMask;
  logic [7:0] next_miscErrorMask;
  logic [7:0] next_zoneOneOffset;
  logic [7:0] next_zoneTwoOffset;
  logic [7:0] next_rdData;
  logic       next_rdHit;

  // Bits outside the write mask keep their stored value
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] wd,
                                       input logic [7:0] wm);
    merge = (cur & ~wm) | (wd & wm);
  endfunction

  // One decode for both ports keeps the read and write maps in step
  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      `SEM_ADDR_DS_INPUT_MASK,
      `SEM_ADDR_DS_VT_MASK,
      `SEM_ADDR_INPUT_ERR_MASK,
      `SEM_ADDR_MISC_ERR_MASK,
      `SEM_ADDR_ZONE_ONE_OFS,
      `SEM_ADDR_ZONE_TWO_OFS: isMapped = 1'b1;
      default:                isMapped = 1'b0;
    endcase
  endfunction

  // Unmapped writes change nothing
  always_comb begin
    next_deepSleepInputMask       = deepSleepInputMask;
    next_deepSleepVoltageTempMask = deepSleepVoltageTempMask;
    next_inputErrorMask           = inputErrorMask;
    next_miscErrorMask            = miscErrorMask;
    next_zoneOneOffset            = zoneOneOffset;
    next_zoneTwoOffset            = zoneTwoOffset;
    if (wrEn && isMapped(regAddr)) begin
      case (regAddr)
        `SEM_ADDR_DS_INPUT_MASK: begin
          next_deepSleepInputMask = wrData;
        end
        `SEM_ADDR_DS_VT_MASK: begin
          next_deepSleepVoltageTempMask = merge(deepSleepVoltageTempMask,
            wrData, `SEM_WMASK_DS_VT);
        end
        `SEM_ADDR_INPUT_ERR_MASK: begin
          next_inputErrorMask = wrData;
        end
        `SEM_ADDR_MISC_ERR_MASK: begin
          next_miscErrorMask = merge(miscErrorMask, wrData,
            `SEM_WMASK_MISC);
        end
        `SEM_ADDR_ZONE_ONE_OFS: begin
          next_zoneOneOffset = merge(zoneOneOffset, wrData,
            `SEM_WMASK_ZONE);
        end
        `SEM_ADDR_ZONE_TWO_OFS: begin
          next_zoneTwoOffset = merge(zoneTwoOffset, wrData,
            `SEM_WMASK_ZONE);
        end
        default: begin
        end
      endcase
    end
  end

  // Only rst restores these; the reset pin changes masking alone
  always_ff @(posedge clk) begin
    if (rst) begin
      deepSleepInputMask       <= `SEM_RST_DS_INPUT_MASK;
      deepSleepVoltageTempMask <= `SEM_RST_DS_VT_MASK;
      inputErrorMask           <= `SEM_RST_INPUT_ERR_MASK;
      miscErrorMask            <= `SEM_RST_MISC_ERR_MASK;
      zoneOneOffset            <= `SEM_RST_ZONE_OFS;
      zoneTwoOffset            <= `SEM_RST_ZONE_OFS;
    end else begin
      deepSleepInputMask       <= next_deepSleepInputMask;
      deepSleepVoltageTempMask <= next_deepSleepVoltageTempMask;
      inputErrorMask           <= next_inputErrorMask;
      miscErrorMask            <= next_miscErrorMask;
      zoneOneOffset            <= next_zoneOneOffset;
      zoneTwoOffset            <= next_zoneTwoOffset;
    end
  end

  // ==========================================================
  // Read port
  // Reserved bits are never stored, so reads return zero there
  always_comb begin
    next_rdData = 8'h00;
    next_rdHit  = 1'b0;
    if (rdEn) begin
      next_rdHit = isMapped(regAddr);
      case (regAddr)
        `SEM_ADDR_DS_INPUT_MASK:  next_rdData = deepSleepInputMask;
        `SEM_ADDR_DS_VT_MASK:     next_rdData = deepSleepVoltageTempMask;
        `SEM_ADDR_INPUT_ERR_MASK: next_rdData = inputErrorMask;
        `SEM_ADDR_MISC_ERR_MASK:  next_rdData = miscErrorMask;
        `SEM_ADDR_ZONE_ONE_OFS:   next_rdData = zoneOneOffset;
        `SEM_ADDR_ZONE_TWO_OFS:   next_rdData = zoneTwoOffset;
        default:                  next_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 8'h00;
      rdHit  <= 1'b0;
    end else begin
      rdData <= next_rdData;
      rdHit  <= next_rdHit;
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic       resetSync1;
  logic       resetSync2;
  logic [7:0] inputSync1;
  logic [7:0] inputSync2;
  logic       next_resetSync1;
  logic       next_resetSync2;
  logic [7:0] next_inputSync1;
  logic [7:0] next_inputSync2;

  // Only the second stage feeds logic; the first may be metastable
  always_comb begin
    next_resetSync1 = ~resetInput_n;
    next_resetSync2 = resetSync1;
    next_inputSync1 = liveInputs;
    next_inputSync2 = inputSync1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resetSync1 <= 1'b0;
      resetSync2 <= 1'b0;
      inputSync1 <= 8'h00;
      inputSync2 <= 8'h00;
    end else begin
      resetSync1 <= next_resetSync1;
      resetSync2 <= next_resetSync2;
      inputSync1 <= next_inputSync1;
      inputSync2 <= next_inputSync2;
    end
  end

  // ==========================================================
  // Event gating
  logic        deepSleep;
  logic        dsTemp;
  logic        dsAnalog13;
  logic        dsAnalog14;
  logic [7:0]  inputKeep;
  sem_events_t next_gatedEvents;
  logic [7:0]  next_liveInputState;

  // Reset pin forces deep-sleep masking regardless of the field
  assign deepSleep = (sleepState == `SEM_SLEEP_DEEP) || resetSync2;
  // Deep-sleep bits act only while deepSleep is high
  assign dsTemp    = deepSleep
                     && deepSleepVoltageTempMask[`SEM_BIT_DS_TEMP];
  assign dsAnalog13 = deepSleep
                      && deepSleepVoltageTempMask[`SEM_BIT_ANALOG13];
  assign dsAnalog14 = deepSleep
                      && deepSleepVoltageTempMask[`SEM_BIT_ANALOG14];

  // ==========================================================
  // Per-input gating
  // Live state is taken before this point, so masks never reach it
  generate
    for (genvar i = 0; i < 8; i++) begin : g_input
      assign inputKeep[i] = ~inputErrorMask[i]
                            & ~(deepSleep & deepSleepInputMask[i]);
    end
  endgenerate

  always_comb begin
    next_gatedEvents = rawEvents;
    next_gatedEvents.inputErr = rawEvents.inputErr
      & inputKeep;
    next_gatedEvents.analog13Err = rawEvents.analog13Err
      & ~dsAnalog13;
    next_gatedEvents.analog14Err = rawEvents.analog14Err
      & ~dsAnalog14;
    next_gatedEvents.zoneTempErr  = rawEvents.zoneTempErr
      & ~{2{dsTemp}};
    next_gatedEvents.zoneDiodeErr = rawEvents.zoneDiodeErr
      & ~{2{dsTemp}};
    next_gatedEvents.regulatorHotEvent = rawEvents.regulatorHotEvent
      & ~miscErrorMask[`SEM_BIT_REG_HOT];
    next_gatedEvents.input8Err = rawEvents.input8Err
      & ~miscErrorMask[`SEM_BIT_INPUT8];
    next_gatedEvents.dynCoreErr = rawEvents.dynCoreErr
      & ~miscErrorMask[`SEM_BIT_DYN_CORE];
    // Live state bypasses every mask
    next_liveInputState = inputSync2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gatedEvents    <= '0;
      liveInputState <= 8'h00;
    end else begin
      gatedEvents    <= next_gatedEvents;
      liveInputState <= next_liveInputState;
    end
  end

  // ==========================================================
  // Zone temperature offset
  sem_temps_t next_adjTemps;
  logic       next_adjValid;
  logic [8:0] zoneOneStep;
  logic [8:0] zoneTwoStep;

  // Offset in degrees scaled to the reading's half-degree LSB
  function automatic logic [8:0] stepOf(input logic [5:0] ofs);
    stepOf = {{2{ofs[5]}}, ofs, 1'b0};
  endfunction

  assign zoneOneStep = stepOf(zoneOneOffset[5:0]);
  assign zoneTwoStep = stepOf(zoneTwoOffset[5:0]);

  // No saturation: a sum past the 9-bit range wraps
  always_comb begin
    next_adjTemps = adjTemps;
    next_adjValid = measValid;
    if (measValid) begin
      next_adjTemps.zoneOne = measTemps.zoneOne + zoneOneStep;
      next_adjTemps.zoneTwo = measTemps.zoneTwo + zoneTwoStep;
    end
  end

  // Downstream consumers take only this adjusted value
  always_ff @(posedge clk) begin
    if (rst) begin
      adjTemps <= '0;
      adjValid <= 1'b0;
    end else begin
      adjTemps <= next_adjTemps;
      adjValid <= next_adjValid;
    end
  end

endmodule

//--- verification/sem_sleep_error_mask_asserts.sv
`timescale 1ns/100ps
module sem_sleep_error_mask_asserts
  import sem_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rdEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  rdData,
  input wire logic        rdHit,
  input wire sem_events_t rawEvents,
  input wire sem_events_t gatedEvents,
  input wire logic [7:0]  liveInputs,
  input wire logic [7:0]  liveInputState,
  input wire sem_temps_t  measTemps,
  input wire logic        measValid,
  input wire sem_temps_t  adjTemps,
  input wire logic        adjValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Register port
  a_unmapped_quiet:
    assert property (rdEn && !(regAddr inside {[8'hea:8'hef]})
      |=> !rdHit && rdData == 8'h00) else $error("unmapped read answered");
  a_mapped_hit:
    assert property (rdEn && regAddr inside {[8'hea:8'hef]} |=> rdHit)
      else $error("mapped read without hit");
  a_read_stands_once:
    assert property (!rdEn |=> !rdHit && rdData == 8'h00)
      else $error("read data held too long");
  a_vt_reserved_zero:
    assert property (rdEn && regAddr == 8'heb |=> rdData[7:4] == 4'h0)
      else $error("reserved bits of voltage mask not zero");
  a_top_reserved_zero:
    assert property (rdEn && regAddr inside {[8'hed:8'hef]}
      |=> rdData[7:6] == 2'h0) else $error("reserved top bits not zero");
  // ==========================================================
  // Gating and temperatures
  a_gate_no_invent:
    assert property (1 |=> (gatedEvents & ~$past(rawEvents)) == '0)
      else $error("gated event without raw event");
  a_live_unmasked:
    assert property ($stable(liveInputs) [*4] |-> liveInputState == liveInputs)
      else $error("live input state differs from inputs");
  a_adj_follows:
    assert property (measValid |=> adjValid)
      else $error("adjusted valid missing");
  a_adj_quiet:
    assert property (!measValid |=> !adjValid)
      else $error("adjusted valid without measurement");
  a_adj_holds:
    assert property (!measValid |=> $stable(adjTemps))
      else $error("adjusted reading moved without measurement");
  a_whole_degree:
    assert property (measValid |=> adjTemps.zoneOne[0] ==
      $past(measTemps.zoneOne[0]) && adjTemps.zoneTwo[0] ==
      $past(measTemps.zoneTwo[0])) else $error("offset not whole degrees");
  c_read: cover property (rdHit);
  c_meas: cover property (adjValid);
  c_masked: cover property (rawEvents.inputErr != gatedEvents.inputErr);
endmodule

bind sem_sleep_error_mask sem_sleep_error_mask_asserts u_chk (.clk, .rst,
  .rdEn, .regAddr, .rdData, .rdHit, .rawEvents, .gatedEvents, .liveInputs,
  .liveInputState, .measTemps, .measValid, .adjTemps, .adjValid);

//--- verification/test_sem_sleep_error_mask.sv
`timescale 1ns/100ps
module test_sem_sleep_error_mask
  import sem_pkg::*;
;
  logic        clk = 0, rst = 1, wrEn = 0, rdEn = 0, rdHit, adjValid;
  logic        measValid = 0, resetInput_n = 1;
  logic [7:0]  regAddr = 0, wrData = 0, liveInputs = 0, rdData, liveInputState;
  logic [1:0]  sleepState = 0;
  sem_events_t rawEvents = '0, gatedEvents;
  sem_temps_t  measTemps = '0, adjTemps;
  int          fail_count = 0, checked = 0, cycles = 0;
  logic [7:0]  rstVal [6] = '{8'hff, 8'h07, 8'hff, 8'h3f, 8'h00, 8'h00};
  logic [7:0]  fullVal [6] = '{8'hff, 8'h0f, 8'hff, 8'h3f, 8'h3f, 8'h3f};

  sem_sleep_error_mask DUT (.clk, .rst, .wrEn, .rdEn, .regAddr, .wrData,
    .rdData, .rdHit, .sleepState, .resetInput_n, .rawEvents, .liveInputs,
    .measTemps, .measValid, .gatedEvents, .liveInputState, .adjTemps,
    .adjValid);

  always #25 clk = ~clk;

  // Tests need about 80 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      end_sim();
    end
  end

  task end_sim();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task cmpReg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmpVal(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Strobe is dropped, then one idle edge, so no double assignment
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    wrData = d;
    wrEn = 1;
    step(1);
    wrEn = 0;
    step(1);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    rdEn = 1;
    step(1);
    rdEn = 0;
    cmpReg(rdData, e);
    cmpReg({7'h00, rdHit}, {7'h00, a inside {[8'hea:8'hef]}});
    step(1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    step(10);
    rst = 0;
    for (int i = 0; i < 6; i++) rd(8'(8'hea + i), rstVal[i]);
    rd(8'he9, 8'h00);
    rd(8'hf0, 8'h00);
    for (int i = 0; i < 6; i++) wr(8'(8'hea + i), 8'hff);
    for (int i = 0; i < 6; i++) rd(8'(8'hea + i), fullVal[i]);
    // Bit 5 of the misc mask stays set, as software must keep it
    wr(8'hec, 8'h5a);
    wr(8'hed, 8'h39);
    rawEvents = '1;
    sleepState = 2'h2;
    step(2);
    cmpVal({1'b0, gatedEvents}, {1'b0, 8'ha5, 6'h3f, 3'h0});
    wr(8'hea, 8'h0f);
    wr(8'heb, 8'h0b);
    sleepState = 2'h3;
    step(2);
    cmpVal({1'b0, gatedEvents}, {1'b0, 8'ha0, 2'b01, 7'h00});
    sleepState = 2'h0;
    resetInput_n = 0;
    step(4);
    cmpVal({1'b0, gatedEvents}, {1'b0, 8'ha0, 2'b01, 7'h00});
    resetInput_n = 1;
    step(4);
    cmpVal({1'b0, gatedEvents}, {1'b0, 8'ha5, 6'h3f, 3'h0});
    wr(8'hee, 8'h1f);
    wr(8'hef, 8'h20);
    measTemps = {9'h010, 9'h010};
    measValid = 1;
    step(1);
    measValid = 0;
    cmpReg({7'h00, adjValid}, 8'h01);
    cmpVal(adjTemps, {9'h04e, 9'h1d0});
    measTemps = '0;
    step(2);
    cmpVal(adjTemps, {9'h04e, 9'h1d0});
    liveInputs = 8'h3c;
    step(4);
    cmpReg(liveInputState, 8'h3c);
    end_sim();
  end
endmodule
